// ### design/cipher_pkg.sv
// Shared constants of the block cipher engine and its host end
package cipher_pkg;
   // ----------------------------------------
   // Address window
   // ----------------------------------------
   localparam logic [7:0] WIN_LO    = 8'h82;
   localparam logic [7:0] CTRL_ADDR = 8'h83;
   localparam logic [7:0] BLK_LO    = 8'h84;
   localparam logic [7:0] BLK_HI    = 8'h93;
   localparam logic [7:0] COPY_ADDR = 8'h94;
   // ----------------------------------------
   // Control byte fields
   // ----------------------------------------
   localparam int         REQ_BIT    = 7;
   localparam int         MODE_LSB   = 4;
   localparam int         DIR_BIT    = 3;
   localparam logic [2:0] MODE_ECB   = 3'h0;
   localparam logic [2:0] MODE_KEY   = 3'h1;
   localparam logic [2:0] MODE_CBC   = 3'h2;
   localparam logic [2:0] MODE_RESET = 3'h0;
   // ----------------------------------------
   // Timing and sizes
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int OP_TIME_NS    = 23400;
   localparam int OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ROUNDS        = 10;
   localparam int BURST_MAX     = 20;
   // ----------------------------------------
   // Cipher arithmetic constants
   // ----------------------------------------
   localparam logic [7:0] RCON_FIRST = 8'h01;
   localparam logic [7:0] RCON_LAST  = 8'h36;
   localparam logic [7:0] POLY       = 8'h1b;
   localparam logic [7:0] SBOX_C     = 8'h63;
   localparam logic [7:0] INV_C      = 8'h05;
endpackage

// ### design/cipher_link_if.sv
// Byte-serial buffer access link between host and cipher engine
`timescale 1ns/10ps
interface cipher_link_if;
   logic       acc_open;   // Opens an access, pulse
   logic       acc_write;  // Access writes
   logic [7:0] acc_addr;   // Start address
   logic       byte_stb;   // One byte moves, pulse
   logic [7:0] byte_wr;    // Byte toward engine
   logic [7:0] byte_rd;    // Byte toward host
   modport dev  (input acc_open, acc_write, acc_addr, byte_stb, byte_wr, output byte_rd);
   modport host (output acc_open, acc_write, acc_addr, byte_stb, byte_wr, input byte_rd);
endinterface

// ### design/cipher_round_core.sv
// Iterative 128-bit block cipher core, one round per clock
`timescale 1ns/10ps
module cipher_round_core (
   // Clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         clear_in,
   // Request
   input  wire logic         start_in,
   input  wire logic         decrypt_in,
   input  wire logic [127:0] key_in,
   input  wire logic [127:0] data_in,
   // Answer
   output logic              done_out,
   output logic [127:0]      result_out,
   output logic [127:0]      round_key_out
);
   import cipher_pkg::*;

   logic [7:0] rcon;
   logic [3:0] round;
   logic       running;
   logic       decrypt;

   function automatic logic [7:0] xt(input logic [7:0] a);
      return {a[6:0], 1'b0} ^ (a[7] ? POLY : 8'h00);
   endfunction
   function automatic logic [7:0] ixt(input logic [7:0] a);
      return a[0] ? (((a ^ POLY) >> 1) | 8'h80) : (a >> 1);
   endfunction
   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) p = p ^ x;
         x = xt(x);
      end
      return p;
   endfunction
   // Field inverse as a to the 254th power
   function automatic logic [7:0] ginv(input logic [7:0] a);
      logic [7:0] x2, x3, x12, x15, x240;
      x2   = gmul(a, a);
      x3   = gmul(x2, a);
      x12  = gmul(gmul(x3, x3), gmul(x3, x3));
      x15  = gmul(x12, x3);
      x240 = gmul(x15, x15);
      x240 = gmul(x240, x240);
      x240 = gmul(x240, x240);
      x240 = gmul(x240, x240);
      return gmul(gmul(x240, x12), x2);
   endfunction
   function automatic logic [7:0] rl(input logic [7:0] b, input int n);
      return 8'((b << n) | (b >> (8 - n)));
   endfunction
   function automatic logic [7:0] sb(input logic [7:0] a, input logic inv);
      logic [7:0] i;
      i = ginv(a);
      if (inv) return ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ INV_C);
      return i ^ rl(i, 1) ^ rl(i, 2) ^ rl(i, 3) ^ rl(i, 4) ^ SBOX_C;
   endfunction
   // Substitution and row shift in one pass
   function automatic logic [127:0] sub_shift(input logic [127:0] s, input logic inv);
      logic [127:0] r;
      int           src;
      r = '0;
      for (int c = 0; c < 4; c++) begin
         for (int w = 0; w < 4; w++) begin
            src = inv ? w + 4 * ((c - w + 4) % 4) : w + 4 * ((c + w) % 4);
            r[127 - 8 * (w + 4 * c) -: 8] = sb(s[127 - 8 * src -: 8], inv);
         end
      end
      return r;
   endfunction
   function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
      logic [127:0] r;
      logic [31:0]  cf;
      r  = '0;
      cf = inv ? 32'h0e0b0d09 : 32'h02030101;
      for (int c = 0; c < 4; c++) begin
         for (int j = 0; j < 4; j++) begin
            for (int k = 0; k < 4; k++) begin
               r[127 - 8 * (j + 4 * c) -: 8] ^= gmul(s[127 - 8 * (k + 4 * c) -: 8],
                                                     cf[31 - 8 * ((k - j + 4) % 4) -: 8]);
            end
         end
      end
      return r;
   endfunction
   function automatic logic [31:0] sub_rot(input logic [31:0] w, input logic [7:0] rc);
      return {sb(w[23:16], 1'b0) ^ rc, sb(w[15:8], 1'b0), sb(w[7:0], 1'b0),
              sb(w[31:24], 1'b0)};
   endfunction
   function automatic logic [127:0] next_key(input logic [127:0] k, input logic [7:0] rc);
      logic [31:0] n0, n1, n2;
      n0 = k[127:96] ^ sub_rot(k[31:0], rc);
      n1 = k[95:64] ^ n0;
      n2 = k[63:32] ^ n1;
      return {n0, n1, n2, k[31:0] ^ n2};
   endfunction
   function automatic logic [127:0] prev_key(input logic [127:0] k, input logic [7:0] rc);
      logic [31:0] p3;
      p3 = k[31:0] ^ k[63:32];
      return {k[127:96] ^ sub_rot(p3, rc), k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], p3};
   endfunction

   // ----------------------------------------
   // Round sequencer
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         result_out    <= '0;
         round_key_out <= '0;
         rcon          <= 8'h00;
         round         <= 4'h0;
         running       <= 1'b0;
         decrypt       <= 1'b0;
         done_out      <= 1'b0;
      end else if (clear_in) begin
         result_out    <= '0;
         round_key_out <= '0;
         running       <= 1'b0;
         done_out      <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in) begin
            result_out    <= data_in ^ key_in;
            round_key_out <= key_in;
            rcon          <= decrypt_in ? RCON_LAST : RCON_FIRST;
            round         <= 4'h1;
            decrypt       <= decrypt_in;
            running       <= 1'b1;
         end else if (running && !decrypt) begin
            round_key_out <= next_key(round_key_out, rcon);
            result_out    <= (round == 4'(ROUNDS) ? sub_shift(result_out, 1'b0)
                             : mix(sub_shift(result_out, 1'b0), 1'b0))
                             ^ next_key(round_key_out, rcon);
            rcon          <= xt(rcon);
         end else if (running) begin
            round_key_out <= prev_key(round_key_out, rcon);
            result_out    <= round == 4'(ROUNDS)
                             ? sub_shift(result_out, 1'b1) ^ prev_key(round_key_out, rcon)
                             : mix(sub_shift(result_out, 1'b1)
                                   ^ prev_key(round_key_out, rcon), 1'b1);
            rcon          <= ixt(rcon);
         end
         if (!start_in && running) begin
            round    <= round + 4'h1;
            running  <= round != 4'(ROUNDS);
            done_out <= round == 4'(ROUNDS);
         end
      end
   end
endmodule // cipher_round_core

// ### design/block_cipher_engine.sv
// Device end: cipher engine behind the buffer access window
// Notes on behaviour
// RQ1: 128-bit block cipher, 128-bit key and block
// RQ2: Codebook both directions, chaining encrypts only
// RQ3: Runs independently of radio activity
// RQ4: All control through window 0x82 to 0x94
// RQ5: Pipelined access writes new, reads previous
// RQ6: Initial key kept apart, never modified
// RQ7: Host order: key, mode, data, start, read
// RQ8: Mode 1 makes block writes load key
// RQ9: Mode at write time picks key page
// RQ10: Direction bit picks encrypt or decrypt
// RQ11: Data block lives at 0x84 to 0x93
// RQ12: Request bit at 0x83 or 0x94 starts
// RQ13: Mode, data, start in one write access
// RQ14: Host writes control and key together
// RQ15: Key page reads return last round key
// RQ16: Access rejected in sleep or reset state
// RQ17: Reset state clears configuration, data, keys
// RQ18: Mode 0 codebook, mode 2 chains XOR
// RQ19: Each byte out lags its write by one
// RQ20: One operation lasts 23.4 microseconds
// RQ21: Request bit clears when result is ready
`timescale 1ns/10ps
module block_cipher_engine (
   // Clock and reset
   input  wire logic   sys_clk_in,
   input  wire logic   rst_n_in,
   // Transceiver state
   input  wire logic   trx_sleep_in,
   input  wire logic   trx_reset_in,
   // Status
   output logic        busy_out,
   output logic        done_out,
   // Link to host
   cipher_link_if.dev  link
);
   import cipher_pkg::*;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [127:0] key_store;   // Initial key
   logic [127:0] last_key;    // Round key after last run
   logic [127:0] data_block;  // Input and result page
   logic [127:0] prev_result; // Chaining value
   logic [2:0]   mode;
   logic         decrypt;
   logic         busy;
   logic [10:0]  op_count;

   // ----------------------------------------
   // Access tracking
   // ----------------------------------------
   logic [7:0]   ptr;
   logic         acc_active;
   logic         acc_write;
   logic [7:0]   rd_byte;

   // Core handshake
   logic         core_start;
   logic         core_done;
   logic [127:0] core_result;
   logic [127:0] core_key;
   logic         res_ready;

   // Decoded strobe
   logic         blocked;
   logic         take_byte;
   logic         wr_byte;
   logic         ctrl_hit;
   logic         blk_hit;
   logic [3:0]   blk_idx;
   logic         start_req;

   // Byte select within a 128-bit block, byte 0 on top
   function automatic logic [7:0] pick(input logic [127:0] b, input logic [3:0] i);
      return b[127 - 8 * i -: 8];
   endfunction

   // ----------------------------------------
   // Decode of the current byte
   // ----------------------------------------
   // Sleep or reset state makes the window deaf
   assign blocked   = trx_sleep_in | trx_reset_in;                // RQ16
   assign take_byte = link.byte_stb & acc_active & ~blocked;      // RQ16
   assign wr_byte   = take_byte & acc_write;
   assign ctrl_hit  = (ptr == CTRL_ADDR) | (ptr == COPY_ADDR);    // RQ12
   assign blk_hit   = (ptr >= BLK_LO) & (ptr <= BLK_HI);          // RQ11
   assign blk_idx   = 4'(ptr - BLK_LO);
   // Start from request bit, ignored while busy or in key mode
   assign start_req = wr_byte & ctrl_hit & link.byte_wr[REQ_BIT]  // RQ12
                      & ~busy & (link.byte_wr[MODE_LSB +: 3] != MODE_KEY);
   assign core_start = start_req;                                 // RQ13

   // ----------------------------------------
   // Access open and address walk
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ptr        <= 8'h00;
         acc_active <= 1'b0;
         acc_write  <= 1'b0;
      end else if (blocked) begin
         acc_active <= 1'b0;                                      // RQ16
      end else if (link.acc_open) begin
         ptr        <= link.acc_addr;
         acc_write  <= link.acc_write;
         // Only the window belongs to this engine
         acc_active <= (link.acc_addr >= WIN_LO)                  // RQ4
                       & (link.acc_addr <= COPY_ADDR);
      end else if (take_byte) begin
         ptr        <= ptr + 8'h01;
         acc_active <= ptr != COPY_ADDR;
      end
   end

   // ----------------------------------------
   // Read-before-write byte out, lags one byte
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_byte <= 8'h00;
      end else if (blocked) begin
         rd_byte <= 8'h00;
      end else if (take_byte) begin
         if (ctrl_hit) begin
            rd_byte <= {busy, mode, decrypt, 3'h0};
         end else if (blk_hit && mode == MODE_KEY) begin
            rd_byte <= pick(last_key, blk_idx);                   // RQ15
         end else if (blk_hit) begin
            rd_byte <= pick(data_block, blk_idx);                 // RQ5 RQ19
         end else begin
            rd_byte <= 8'h00;
         end
      end
   end
   assign link.byte_rd = rd_byte;

   // ----------------------------------------
   // Control byte, also reached at its copy
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode    <= MODE_RESET;
         decrypt <= 1'b0;
      end else if (trx_reset_in) begin
         mode    <= MODE_RESET;                                   // RQ17
         decrypt <= 1'b0;
      end else if (wr_byte && ctrl_hit) begin
         mode    <= link.byte_wr[MODE_LSB +: 3];                  // RQ8 RQ18
         decrypt <= link.byte_wr[DIR_BIT];                        // RQ10
      end
   end

   // ----------------------------------------
   // Key page: initial key store
   // ----------------------------------------
   // Written only by the host, never by a run
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         key_store <= '0;
      end else if (trx_reset_in) begin
         key_store <= '0;                                         // RQ17
      end else if (wr_byte && blk_hit && mode == MODE_KEY) begin
         key_store[127 - 8 * blk_idx -: 8] <= link.byte_wr;       // RQ6 RQ8 RQ9
      end
   end

   // ----------------------------------------
   // Data page and chaining value
   // ----------------------------------------
   // A finished result overwrites the page
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_block  <= '0;
         prev_result <= '0;
         last_key    <= '0;
      end else if (trx_reset_in) begin
         data_block  <= '0;                                       // RQ17
         prev_result <= '0;
         last_key    <= '0;
      end else if (busy && op_count == 11'd0 && res_ready) begin
         data_block  <= core_result;                              // RQ21
         prev_result <= core_result;                              // RQ18
         last_key    <= core_key;                                 // RQ15
      end else if (wr_byte && blk_hit && mode != MODE_KEY) begin
         data_block[127 - 8 * blk_idx -: 8] <= link.byte_wr;      // RQ9 RQ11
      end
   end

   // ----------------------------------------
   // Operation timer and request bit
   // ----------------------------------------
   // Run lasts a fixed time, held by a counter
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy     <= 1'b0;
         op_count <= 11'd0;
         done_out <= 1'b0;
      end else if (trx_reset_in) begin
         busy     <= 1'b0;                                        // RQ17
         op_count <= 11'd0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_req) begin
            busy     <= 1'b1;
            op_count <= 11'(OP_CYCLES - 1);                       // RQ20
         end else if (busy && op_count != 11'd0) begin
            op_count <= op_count - 11'd1;                         // RQ20
         end else if (busy && res_ready) begin
            busy     <= 1'b0;                                     // RQ21
            done_out <= 1'b1;
         end
      end
   end
   assign busy_out = busy;

   // Core result held until the timer ends
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         res_ready <= 1'b0;
      end else if (trx_reset_in || start_req) begin
         res_ready <= 1'b0;
      end else if (core_done) begin
         res_ready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Cipher core
   // ----------------------------------------
   // Chaining forces encryption and folds in last result
   cipher_round_core u_core (                                     // RQ1 RQ3
      .sys_clk_in    (sys_clk_in),
      .rst_n_in      (rst_n_in),
      .clear_in      (trx_reset_in),
      .start_in      (core_start),
      .decrypt_in    (link.byte_wr[DIR_BIT]                       // RQ2 RQ10
                      & (link.byte_wr[MODE_LSB +: 3] != MODE_CBC)),
      .key_in        (key_store),                                 // RQ6
      .data_in       ((link.byte_wr[MODE_LSB +: 3] == MODE_CBC)   // RQ18
                      ? data_block ^ prev_result : data_block),
      .done_out      (core_done),
      .result_out    (core_result),
      .round_key_out (core_key)
   );

endmodule // block_cipher_engine

// ### design/cipher_host_port.sv
// Host end: runs one buffer access burst on the link
`timescale 1ns/10ps
module cipher_host_port (
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   // User request
   input  wire logic        start_in,
   input  wire logic        write_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [4:0]  count_in,
   input  wire logic [159:0] wbuf_in,
   // User answer
   output logic             busy_out,
   output logic             done_out,
   output logic [159:0]     rbuf_out,
   // Link to engine
   cipher_link_if.host      link
);
   import cipher_pkg::*;

   typedef enum logic [2:0] {IDLE, OPEN, SEND, TAKE} host_state_t;
   host_state_t  state;
   logic [159:0] wbuf;
   logic [4:0]   left;
   logic [4:0]   idx;
   logic         write;
   logic [7:0]   addr;

   // ----------------------------------------
   // Burst sequencer, one byte per two cycles
   // ----------------------------------------
   // A burst from 0x83 carries control, block and start
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state    <= IDLE;
         wbuf     <= '0;
         left     <= 5'd0;
         idx      <= 5'd0;
         write    <= 1'b0;
         addr     <= 8'h00;
         rbuf_out <= '0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         unique case (state)
            IDLE: begin
               if (start_in && count_in != 5'd0 && count_in <= 5'(BURST_MAX)) begin
                  wbuf  <= wbuf_in;                               // RQ14
                  left  <= count_in;
                  idx   <= 5'd0;
                  write <= write_in;
                  addr  <= addr_in;
                  state <= OPEN;
               end
            end
            OPEN: begin
               state <= SEND;
            end
            SEND: begin
               state <= TAKE;
               left  <= left - 5'd1;
            end
            TAKE: begin
               // Byte k answered is the prior content of byte k
               rbuf_out[159 - 8 * idx -: 8] <= link.byte_rd;      // RQ5
               idx <= idx + 5'd1;
               if (left == 5'd0) begin
                  state    <= IDLE;
                  done_out <= 1'b1;
               end else begin
                  state <= SEND;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Link drive
   // ----------------------------------------
   assign link.acc_open  = state == OPEN;
   assign link.acc_write = write;
   assign link.acc_addr  = addr;
   assign link.byte_stb  = state == SEND;                         // RQ7 RQ13
   assign link.byte_wr   = wbuf[159 - 8 * idx -: 8];
   assign busy_out       = state != IDLE;

endmodule // cipher_host_port

// ### verif/cipher_link_monitor.sv
// Checker of the cipher link and engine status
`timescale 1ns/10ps
module cipher_link_monitor (
   // Clock, reset and engine status
   input wire logic       sys_clk_in,
   input wire logic       rst_n_in,
   input wire logic       trx_sleep_in,
   input wire logic       trx_reset_in,
   input wire logic       busy_out,
   input wire logic       done_out,
   // Link signals
   input wire logic       acc_open,
   input wire logic       byte_stb,
   input wire logic [7:0] byte_rd
);
   import cipher_pkg::*;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [11:0] run_cnt;
   logic        blk;
   assign blk = trx_sleep_in | trx_reset_in;
   // Counts busy cycles of the running operation
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         run_cnt <= 12'h000;
      else
         run_cnt <= busy_out ? run_cnt + 12'h001 : 12'h000;
   end
   chk_open_then_byte: assert property (acc_open |=> !acc_open && byte_stb)
      else $error("no byte after open");
   chk_bytes_spaced: assert property (byte_stb |=> !byte_stb)
      else $error("strobes not spaced");
   chk_blocked_zero: assert property (blk ##1 blk |-> byte_rd == 8'h00)
      else $error("read data while blocked");
   chk_read_holds: assert property (!byte_stb && !blk |=> blk || $stable(byte_rd))
      else $error("read byte moved without strobe");
   chk_busy_cause: assert property ($rose(busy_out) |-> $past(byte_stb))
      else $error("start without written byte");
   chk_run_length: assert property (done_out |-> run_cnt >= OP_CYCLES - 2 && run_cnt <= OP_CYCLES)
      else $error("operation length off");
   chk_busy_bound: assert property (run_cnt <= OP_CYCLES + 1)
      else $error("request never cleared");
   chk_done_pulse: assert property (done_out |=> !done_out && !busy_out)
      else $error("done not a pulse");
   chk_reset_clears: assert property (trx_reset_in |=> !busy_out)
      else $error("busy survives reset state");
   cover property (done_out);
   cover property (blk && byte_stb);
   cover property (acc_open ##1 byte_stb ##2 byte_stb);
endmodule // cipher_link_monitor

// ### verif/block_cipher_engine_test.sv
// Self-checking bench for the cipher engine and its host end
`timescale 1ns/10ps
module block_cipher_engine_test;
   import cipher_pkg::*;
   logic         sys_clk_in, rst_n_in, trx_sleep_in, trx_reset_in, e_busy, e_done;
   logic         start_in, write_in, h_busy, h_done;
   logic [7:0]   addr_in;
   logic [4:0]   count_in;
   logic [159:0] wbuf_in, rbuf;
   logic [127:0] key, p, q, c, r, res, dpage;
   int           errors, checks, i;
   cipher_link_if link ();
   block_cipher_engine i_block_cipher_engine (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .trx_sleep_in(trx_sleep_in), .trx_reset_in(trx_reset_in), .busy_out(e_busy),
      .done_out(e_done), .link(link));
   cipher_host_port i_cipher_host_port (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .start_in(start_in), .write_in(write_in), .addr_in(addr_in), .count_in(count_in),
      .wbuf_in(wbuf_in), .busy_out(h_busy), .done_out(h_done), .rbuf_out(rbuf), .link(link));
   cipher_link_monitor i_cipher_link_monitor (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .trx_sleep_in(trx_sleep_in), .trx_reset_in(trx_reset_in), .busy_out(e_busy),
      .done_out(e_done), .acc_open(link.acc_open), .byte_stb(link.byte_stb),
      .byte_rd(link.byte_rd));
   // ----------------------------------------
   // Compare, access and closing tasks
   // ----------------------------------------
   task automatic cmp(input logic [127:0] got, exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Waits under a bound for a one-cycle flag
   task automatic wait_flag(input int lim, input bit eng);
      for (i = 0; i < lim; i++) begin
         @(negedge sys_clk_in);
         if ((eng ? e_done : h_done) === 1'b1)
            return;
      end
      errors++;
      test_done();
   endtask
   task automatic burst(input logic w, input logic [7:0] a, input logic [4:0] n,
                        input logic [159:0] d);
      @(negedge sys_clk_in);
      start_in = 1'b1;
      write_in = w;
      addr_in  = a;
      count_in = n;
      wbuf_in  = d;
      @(negedge sys_clk_in);
      start_in = 1'b0;
      wait_flag(60, 1'b0);
      cmp(h_busy, 1'b0);
   endtask
   // Control, block and start in one access; old data page bytes come back outside key mode
   task automatic wr_blk(input logic [7:0] ctl, input logic [127:0] b, input logic [7:0] st);
      burst(1'b1, CTRL_ADDR, 5'd18, {ctl, b, st, 16'h0000});
      if (ctl[6:4] != MODE_KEY) begin
         cmp(rbuf[151:24], dpage);
         dpage = b;
      end
   endtask
   task automatic rd_blk();
      burst(1'b0, BLK_LO, 5'd16, 160'h0);
      res = rbuf[159:32];
   endtask
   task automatic run(input logic [7:0] ctl, input logic [127:0] b);
      wr_blk(ctl, b, ctl | 8'h80);
      burst(1'b0, CTRL_ADDR, 5'd1, 160'h0);
      cmp(rbuf[159:152], ctl | 8'h80);
      wait_flag(OP_CYCLES + 40, 1'b1);
      burst(1'b0, COPY_ADDR, 5'd1, 160'h0);
      cmp(rbuf[159:152], ctl);
      rd_blk();
      dpage = res;
   endtask
   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst_n_in, trx_sleep_in, trx_reset_in, start_in, write_in, addr_in} = '0;
      {count_in, wbuf_in, errors, checks, dpage} = '0;
      void'($urandom(89685));
      {key, p, q} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
                     $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      repeat (12) @(negedge sys_clk_in);
      rst_n_in = 1'b1;
      // Known-answer run of the cipher standard, started at the control byte
      wr_blk(8'h10, 128'h000102030405060708090a0b0c0d0e0f, 8'h00);
      wr_blk(8'h00, 128'h00112233445566778899aabbccddeeff, 8'h00);
      burst(1'b1, CTRL_ADDR, 5'd1, {8'h80, 152'h0});
      wait_flag(OP_CYCLES + 40, 1'b1);
      rd_blk();
      cmp(res, 128'h69c4e0d86a7b0430d8cdb78070b4c55a);
      dpage = res;
      burst(1'b1, CTRL_ADDR, 5'd1, {8'h90, 152'h0});
      cmp(e_busy, 1'b0);
      rd_blk();
      cmp(res, 128'h13111d7fe3944a17f307a78b4d2b30c5);
      wr_blk(8'h10, key, 8'h00);
      run(8'h00, p);
      c = res;
      run(8'h00, p);
      cmp(res, c);
      burst(1'b1, CTRL_ADDR, 5'd1, {8'h10, 152'h0});
      rd_blk();
      wr_blk(8'h10, res, 8'h00);
      run(8'h08, c);
      cmp(res, p);
      wr_blk(8'h10, key, 8'h00);
      run(8'h00, p);
      run(8'h20, q);
      r = res;
      run(8'h00, q ^ c);
      cmp(res, r);
      burst(1'b0, WIN_LO, 5'd1, 160'h0);
      cmp(rbuf[159:152], 8'h00);
      trx_sleep_in = 1'b1;
      burst(1'b1, CTRL_ADDR, 5'd18, {8'h00, ~dpage, 8'h80, 16'h0000});
      trx_sleep_in = 1'b0;
      rd_blk();
      cmp(res, dpage);
      trx_reset_in = 1'b1;
      repeat (2) @(negedge sys_clk_in);
      trx_reset_in = 1'b0;
      rd_blk();
      cmp(res, 128'h0);
      test_done();
   end
endmodule // block_cipher_engine_test
